// ### bench/sbm_checker.sv
`timescale 1ns/1ns
module sbm_checker (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic host_cs_task,
  input wire logic host_cs_aux,
  input wire logic [2:0] host_addr,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [15:0] host_wdata,
  input wire logic host_irq,
  input wire logic [7:0] cp_addr,
  input wire logic cp_wr,
  input wire logic cp_rd,
  input wire logic [7:0] cp_wdata,
  input wire logic processor_wakeup_n,
  input wire sbm_pkg::sbm_dcbus_t dc_bus,
  input wire logic dc_back,
  input wire sbm_pkg::sbm_ram_t ram,
  input wire logic ecc7_mode,
  input wire logic sleep_mode
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic strobe;
  assign strobe = !ram.we_n || !ram.oe_n;

  one_strobe_a: assert property (!(!ram.we_n && !ram.oe_n))
    else $error("memory strobes overlap");
  mem_recover_a: assert property (strobe |=> !strobe [*2])
    else $error("memory cycle without idle gap");
  irq_clear_a: assert property ((host_rd || host_wr) && host_cs_task && host_addr == 3'h7 && !cp_rd
    |-> ##2 !host_irq) else $error("host irq not cleared by status or command");
  chip_write_a: assert property (cp_wr && cp_addr[5:3] == 3'h2 |=> !dc_bus.cs_n && !dc_bus.wr_n
    && dc_bus.addr == $past(cp_addr[2:0]) && dc_bus.dout == $past(cp_wdata)) else $error("chip write wrong");
  chip_pulse_a: assert property ((!dc_bus.rd_n || !dc_bus.wr_n) && !cp_wr && !cp_rd
    |=> dc_bus.rd_n && dc_bus.wr_n) else $error("chip strobe too long");
  ecc_src_a: assert property ($rose(ecc7_mode) |-> $past(cp_rd && cp_addr[5:0] == 6'h23))
    else $error("ecc mode set without command");
  sleep_src_a: assert property ($rose(sleep_mode) |-> $past(cp_rd && cp_addr[5:0] == 6'h22))
    else $error("sleep set without command");
  idle_cmd_a: assert property (cp_rd && cp_addr[5:0] == 6'h27 |=> !sleep_mode)
    else $error("idle command left sleep on");
  back_pulse_a: assert property (dc_back |=> !dc_back)
    else $error("chip ack longer than one cycle");
  wake_rst_a: assert property (host_wr && host_cs_aux && host_addr == 3'h6 && host_wdata[2]
    |-> ##[1:2] !processor_wakeup_n) else $error("no wakeup on programmed reset");
endmodule

// ### bench/sbm_ram_model.sv
`timescale 1ns/1ns
module sbm_ram_model (
  input wire logic clk,
  input wire sbm_pkg::sbm_ram_t ram,
  output logic [7:0] ram_din
);
  logic [7:0] mem [0:16383];
  logic [7:0] last = 8'h00;
  always_ff @(posedge clk) begin
    if (!ram.we_n) begin
      mem[{ram.addr, ram.bank}] <= ram.dout;
    end
    if (!ram.oe_n) begin
      last <= mem[{ram.addr, ram.bank}];
    end
  end
  // Released bus shows inverted data so a late sample cannot pass by luck
  assign ram_din = ram.oe_n ? ~last : mem[{ram.addr, ram.bank}];
endmodule

// ### bench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic host_cs_task = 1'b0;
  logic host_cs_aux = 1'b0;
  logic [2:0] host_addr = 3'h0;
  logic host_wr = 1'b0;
  logic host_rd = 1'b0;
  logic [15:0] host_wdata = 16'h0000;
  logic [15:0] host_rdata;
  logic host_irq;
  logic [7:0] cp_addr = 8'h00;
  logic cp_wr = 1'b0;
  logic cp_rd = 1'b0;
  logic [7:0] cp_wdata = 8'h00;
  logic [7:0] cp_rdata;
  logic processor_wakeup_n;
  sbm_pkg::sbm_dcbus_t dc_bus;
  logic [7:0] dc_din = 8'h00;
  logic dc_brq = 1'b0;
  logic dc_back;
  sbm_pkg::sbm_ram_t ram;
  logic [7:0] ram_din;
  logic ecc7_mode;
  logic sleep_mode;
  logic [15:0] got;
  logic [7:0] wbytes [4] = '{8'h5A, 8'hA5, 8'h34, 8'h12};
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;

  sbm_top i_sbm_top (.sys_clk(sys_clk), .rstn(rstn), .host_cs_task(host_cs_task), .host_cs_aux(host_cs_aux),
    .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .host_irq(host_irq), .cp_addr(cp_addr), .cp_wr(cp_wr), .cp_rd(cp_rd),
    .cp_wdata(cp_wdata), .cp_rdata(cp_rdata), .processor_wakeup_n(processor_wakeup_n), .dc_bus(dc_bus),
    .dc_din(dc_din), .dc_brq(dc_brq), .dc_back(dc_back), .ram(ram), .ram_din(ram_din),
    .ecc7_mode(ecc7_mode), .sleep_mode(sleep_mode));
  sbm_ram_model i_sbm_ram_model (.clk(sys_clk), .ram(ram), .ram_din(ram_din));

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      test_done();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cpw(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    cp_addr <= a;
    cp_wdata <= d;
    cp_wr <= 1'b1;
    @(posedge sys_clk);
    cp_wr <= 1'b0;
  endtask

  task automatic cpr(input logic [7:0] a);
    @(posedge sys_clk);
    cp_addr <= a;
    cp_rd <= 1'b1;
    @(posedge sys_clk);
    cp_rd <= 1'b0;
    #1;
    got = {8'h00, cp_rdata};
  endtask

  task automatic hacc(input logic aux, input logic wr, input logic [2:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    host_cs_task <= !aux;
    host_cs_aux <= aux;
    host_addr <= a;
    host_wdata <= d;
    host_wr <= wr;
    host_rd <= !wr;
    @(posedge sys_clk);
    host_wr <= 1'b0;
    host_rd <= 1'b0;
    host_cs_task <= 1'b0;
    host_cs_aux <= 1'b0;
    #1;
    got = host_rdata;
  endtask

  initial begin
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    tick(3);
    chk("wakeup_n", processor_wakeup_n, 16'h1);
    chk("irq", host_irq, 16'h0);
    hacc(1'b1, 1'b1, 3'h6, 16'h0000);
    cpr(8'h22);
    tick(1);
    chk("sleep", sleep_mode, 16'h1);
    cpr(8'h24);
    tick(2);
    chk("irq", host_irq, 16'h1);
    hacc(1'b1, 1'b1, 3'h6, 16'h0002);
    tick(2);
    chk("irq", host_irq, 16'h0);
    hacc(1'b1, 1'b1, 3'h6, 16'h0000);
    tick(2);
    chk("irq", host_irq, 16'h1);
    hacc(1'b1, 1'b0, 3'h6, 16'h0000);
    tick(2);
    chk("irq", host_irq, 16'h1);
    hacc(1'b0, 1'b0, 3'h7, 16'h0000);
    tick(2);
    chk("irq", host_irq, 16'h0);
    cpr(8'hE4);
    tick(2);
    chk("irq", host_irq, 16'h1);
    hacc(1'b0, 1'b1, 3'h7, 16'h0020);
    cpr(8'h22);
    tick(2);
    chk("irq", host_irq, 16'h0);
    cpw(8'h20, 8'h05);
    cpr(8'h20);
    chk("host blk", got, 16'h0005);
    cpw(8'h61, 8'h1F);
    cpr(8'h21);
    chk("disk blk", got, 16'h001F);
    cpw(8'h22, 8'h00);
    cpr(8'h20);
    chk("host blk", got, 16'h0000);
    cpw(8'h23, 8'h00);
    cpr(8'h21);
    chk("disk blk", got, 16'h0000);
    cpr(8'h23);
    tick(1);
    chk("ecc7", ecc7_mode, 16'h1);
    cpw(8'h24, 8'h00);
    hacc(1'b1, 1'b0, 3'h6, 16'h0000);
    chk("drq", {15'h0000, got[3]}, 16'h0001);
    cpr(8'h27);
    tick(1);
    chk("sleep", sleep_mode, 16'h0);
    hacc(1'b1, 1'b0, 3'h6, 16'h0000);
    chk("drq", {15'h0000, got[3]}, 16'h0000);
    cpw(8'h30, 8'hFF);
    cpr(8'h30);
    chk("reserved", got, 16'h0000);
    // Words spaced past two memory cycles so the posted pair lands
    hacc(1'b0, 1'b1, 3'h0, 16'hA55A);
    tick(8);
    hacc(1'b0, 1'b1, 3'h0, 16'h1234);
    tick(8);
    for (int i = 0; i < 4; i++) chk("ram", {8'h00, i_sbm_ram_model.mem[i]}, {8'h00, wbytes[i]});
    cpw(8'h22, 8'h00);
    cpr(8'h25);
    tick(8);
    hacc(1'b0, 1'b0, 3'h0, 16'h0000);
    chk("word", got, 16'hA55A);
    tick(8);
    hacc(1'b0, 1'b0, 3'h0, 16'h0000);
    chk("word", got, 16'h1234);
    cpw(8'h03, 8'h44);
    hacc(1'b0, 1'b0, 3'h3, 16'h0000);
    chk("copy", {8'h00, got[7:0]}, 16'h0044);
    cpw(8'h52, 8'h3C);
    dc_din <= 8'h77;
    cpr(8'h15);
    cpr(8'h15);
    chk("chip rd", got, 16'h0077);
    // Read mode first, else a write-mode prefetch steps the cleared counter
    cpw(8'h25, 8'h00);
    cpw(8'h23, 8'h00);
    @(posedge sys_clk);
    dc_din <= 8'h9E;
    dc_brq <= 1'b1;
    for (int k = 0; k < 20 && dc_back !== 1'b1; k++) tick(1);
    @(posedge sys_clk);
    dc_brq <= 1'b0;
    tick(8);
    chk("disk byte", {8'h00, i_sbm_ram_model.mem[0]}, 16'h009E);
    // Back to write mode; let the prefetch settle before clearing the counter
    cpr(8'h27);
    tick(8);
    cpw(8'h23, 8'h00);
    tick(8);
    @(posedge sys_clk);
    dc_brq <= 1'b1;
    tick(1);
    chk("disk ack", dc_back, 16'h1);
    chk("disk out", {8'h00, dc_bus.dout}, 16'h009E);
    @(posedge sys_clk);
    dc_brq <= 1'b0;
    cpr(8'h07);
    chk("cmd copy", got, 16'h0020);
    chk("wakeup_n", processor_wakeup_n, 16'h1);
    cpw(8'h20, 8'h0A);
    hacc(1'b1, 1'b1, 3'h6, 16'h0004);
    tick(2);
    chk("wakeup_n", processor_wakeup_n, 16'h0);
    hacc(1'b1, 1'b1, 3'h6, 16'h0000);
    cpr(8'h20);
    chk("host blk", got, 16'h0000);
    cpr(8'h07);
    tick(1);
    chk("wakeup_n", processor_wakeup_n, 16'h1);
    test_done();
  end
endmodule

bind sbm_top sbm_checker i_sbm_checker (.sys_clk(sys_clk), .rstn(rstn), .host_cs_task(host_cs_task),
  .host_cs_aux(host_cs_aux), .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd),
  .host_wdata(host_wdata), .host_irq(host_irq), .cp_addr(cp_addr), .cp_wr(cp_wr), .cp_rd(cp_rd),
  .cp_wdata(cp_wdata), .processor_wakeup_n(processor_wakeup_n), .dc_bus(dc_bus), .dc_back(dc_back),
  .ram(ram), .ecc7_mode(ecc7_mode), .sleep_mode(sleep_mode));

// ### hdl/sbm_addr_ctr.sv
`timescale 1ns/1ns
module sbm_addr_ctr #(
  parameter int W = 14,
  parameter int BLK_LSB = 9
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic ld,
  input wire logic [W-BLK_LSB-1:0] ld_blk,
  input wire logic inc,
  output logic [W-1:0] q
);

  // Block load starts the counter at a block boundary
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else if (clr) begin
      q <= '0;
    end else if (ld) begin
      q <= {ld_blk, {BLK_LSB{1'b0}}};
    end else if (inc) begin
      q <= q + {{(W-1){1'b0}}, 1'b1};
    end
  end

endmodule

// ### hdl/sbm_defines.svh
`ifndef SBM_DEFINES_SVH
`define SBM_DEFINES_SVH

// Processor addresses after the two high bits are dropped
`define SBM_CP_PAGE_OWN 2'h0
`define SBM_CP_PAGE_DC 2'h1
`define SBM_CP_PAGE_SUP 2'h2
`define SBM_CP_HBLK 6'h20
`define SBM_CP_DBLK 6'h21
`define SBM_CP_HCLR 6'h22
`define SBM_CP_DCLR 6'h23
`define SBM_CP_DRQ 6'h24
`define SBM_CP_MODE 6'h25
`define SBM_CP_MULTI 6'h26
`define SBM_CP_SECT 6'h27

// Host register indices inside each decoded range
`define SBM_H_DATA 3'h0
`define SBM_H_STAT 3'h7
`define SBM_H_AUX 3'h6

// Status and auxiliary control fields
`define SBM_ST_BSY 7
`define SBM_ST_DRQ 3
`define SBM_AUX_RST 2
`define SBM_AUX_IDS 1
`define SBM_AUX_RESET 8'h02
`define SBM_BUSY_RESET 1'h1

// Address counter layout
`define SBM_CTR_W 14
`define SBM_BLK_LSB 9
`define SBM_SEC_LAST 9'h1FF

`endif

// ### hdl/sbm_pkg.sv
package sbm_pkg;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_ACCESS, SEQ_RECOVER} sbm_seq_state_t;

  typedef struct packed {
    logic [12:0] addr;
    logic bank;
    logic we_n;
    logic oe_n;
    logic [7:0] dout;
  } sbm_ram_t;

  typedef struct packed {
    logic [2:0] addr;
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic [7:0] dout;
  } sbm_dcbus_t;

  typedef struct packed {
    logic [13:0] addr;
    logic we;
    logic [7:0] wdata;
  } sbm_memreq_t;

endpackage

// ### hdl/sbm_seq.sv
`timescale 1ns/1ns
module sbm_seq (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic host_req,
  input wire sbm_pkg::sbm_memreq_t host_mr,
  input wire logic dc_req,
  input wire sbm_pkg::sbm_memreq_t dc_mr,
  input wire logic [7:0] ram_din,
  output sbm_pkg::sbm_ram_t ram,
  output logic host_done,
  output logic dc_done,
  output logic [7:0] rd_byte
);

  sbm_pkg::sbm_seq_state_t state_reg;
  logic gnt_host_reg;
  sbm_pkg::sbm_memreq_t pick;

  assign pick = host_req ? host_mr : dc_mr;

  // One grant per memory cycle, then a recovery slot
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= sbm_pkg::SEQ_IDLE;
      gnt_host_reg <= 1'b0;
    end else begin
      case (state_reg)
        sbm_pkg::SEQ_IDLE: begin
          if (host_req || dc_req) begin
            state_reg <= sbm_pkg::SEQ_ACCESS;
            gnt_host_reg <= host_req;
          end
        end
        sbm_pkg::SEQ_ACCESS: state_reg <= sbm_pkg::SEQ_RECOVER;
        sbm_pkg::SEQ_RECOVER: state_reg <= sbm_pkg::SEQ_IDLE;
        default: state_reg <= sbm_pkg::SEQ_IDLE;
      endcase
    end
  end

  // Memory strobes; address of the granted requester goes out
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ram <= '{addr: 13'h0000, bank: 1'b0, we_n: 1'b1, oe_n: 1'b1, dout: 8'h00};
    end else if (state_reg == sbm_pkg::SEQ_IDLE && (host_req || dc_req)) begin
      ram.addr <= pick.addr[13:1];
      ram.bank <= pick.addr[0];
      ram.we_n <= ~pick.we;
      ram.oe_n <= pick.we;
      ram.dout <= pick.wdata;
    end else begin
      ram.we_n <= 1'b1;
      ram.oe_n <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      host_done <= 1'b0;
      dc_done <= 1'b0;
      rd_byte <= 8'h00;
    end else begin
      host_done <= state_reg == sbm_pkg::SEQ_ACCESS && gnt_host_reg;
      dc_done <= state_reg == sbm_pkg::SEQ_ACCESS && !gnt_host_reg;
      if (state_reg == sbm_pkg::SEQ_ACCESS) begin
        rd_byte <= ram_din;
      end
    end
  end

endmodule

// ### hdl/sbm_top.sv
// Functional notes
// - Host interrupt only when level set, disable bit clear and not busy.
// - Level clears on host command write, status read, programmed or master reset.
// - Support address 20 reaches host block counter, 21 the disk-side one.
// - Write 22 clears host counter; read 22 enters sleep and clears busy.
// - Write 23 clears disk-side counter; read 23 selects seven-byte ECC.
// - 24: write sets data request, read sets interrupt; 25: read mode, prefetch.
// - Write 26 sets multi-sector mode; read 26 clears it.
// - Write 27 loads sector block counter; read 27 enters idle mode.
// - Processor 00-07 own task file, 10-17 chip task file, 30-3F reserved.
// - Top two processor address bits ignored in decoding.
// - Support commands come only from the processor port, never the host.
// - Host ranges chosen externally; individual registers decoded here.
// - Task file image registers; host sees copies, processor sees both.
// - Low-byte pipeline registers on host and disk sides for concurrency.
// - Arbitrate memory requests; granted counter drives memory address.
// - Clocked sequencer favours host and makes memory strobes.
// - 14-bit counters; upper 13 bits address memory, low bit picks byte.
// - All chip data, address, select and strobe switching done here.
// - Active-low wake-up to the processor.
// - Host write: high byte held, low byte posted, both to RAM later.
// - Host reads prefetch two bytes; each data read starts the next two.
// - Disable bit does not clear pending level; it shows once re-enabled.
// - Host data port moves one 16-bit word per access.
`timescale 1ns/1ns
`include "sbm_defines.svh"
module sbm_top (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic host_cs_task,
  input wire logic host_cs_aux,
  input wire logic [2:0] host_addr,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [15:0] host_wdata,
  output logic [15:0] host_rdata,
  output logic host_irq,
  input wire logic [7:0] cp_addr,
  input wire logic cp_wr,
  input wire logic cp_rd,
  input wire logic [7:0] cp_wdata,
  output logic [7:0] cp_rdata,
  output logic processor_wakeup_n,
  output sbm_pkg::sbm_dcbus_t dc_bus,
  input wire logic [7:0] dc_din,
  input wire logic dc_brq,
  output logic dc_back,
  output sbm_pkg::sbm_ram_t ram,
  input wire logic [7:0] ram_din,
  output logic ecc7_mode,
  output logic sleep_mode
);

  logic [1:0] rst_sync;
  logic rst_n_i;
  logic [5:0] cp_a;
  logic [7:0] aux_reg;
  logic soft_clr;
  logic busy_reg, irq_lvl_reg, drq_reg, read_mode_reg, multi_reg;
  logic [7:0] sec_blk_reg, stat_img_reg, cmd_reg, dc_hold_reg;
  logic [7:0] tf_reg [1:6];
  logic [7:0] host_lo_reg, host_hi_reg, dc_pipe_reg;
  logic [1:0] host_pend_reg;
  logic host_dir_wr_reg, dc_vld_reg, dc_pend_reg, dc_rd_pend_reg;
  logic [13:0] hc_q, dcc_q;
  logic host_done, dc_done;
  logic [7:0] rd_byte;
  sbm_pkg::sbm_memreq_t host_mr, dc_mr;
  logic h_data_wr, h_data_rd, h_cmd_wr, h_stat_rd, h_aux_wr, h_tf_wr;
  logic sec_end, idle_cmd;
  logic [7:0] status;

  function automatic logic cp_hit(input logic [5:0] a, input logic [5:0] code);
    cp_hit = (a == code);
  endfunction

  function automatic logic host_hit(input logic cs, input logic [2:0] a, input logic [2:0] idx);
    host_hit = cs && (a == idx);
  endfunction

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n_i = rst_sync[1];

  assign cp_a = cp_addr[5:0];

  // Host decode; support commands have no path from this port
  assign h_data_wr = host_wr && host_hit(host_cs_task, host_addr, `SBM_H_DATA);
  assign h_data_rd = host_rd && host_hit(host_cs_task, host_addr, `SBM_H_DATA);
  assign h_cmd_wr = host_wr && host_hit(host_cs_task, host_addr, `SBM_H_STAT);
  assign h_stat_rd = host_rd && host_hit(host_cs_task, host_addr, `SBM_H_STAT);
  assign h_aux_wr = host_wr && host_hit(host_cs_aux, host_addr, `SBM_H_AUX);
  assign h_tf_wr = host_wr && host_cs_task && host_addr != `SBM_H_DATA && host_addr != `SBM_H_STAT;

  assign soft_clr = aux_reg[`SBM_AUX_RST];
  assign idle_cmd = cp_rd && cp_hit(cp_a, `SBM_CP_SECT);
  assign sec_end = host_done && hc_q[8:0] == `SBM_SEC_LAST;
  assign status = {busy_reg, stat_img_reg[6:4], drq_reg, stat_img_reg[2:0]};

  // Programmed reset holds the section clear while the bit stays set
  always_ff @(posedge sys_clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aux_reg <= `SBM_AUX_RESET;
    end else if (h_aux_wr) begin
      aux_reg <= {5'h00, host_wdata[`SBM_AUX_RST], host_wdata[`SBM_AUX_IDS], 1'b0};
    end
  end

  // Command write sets busy even if sleep is ordered in the same cycle
  always_ff @(posedge sys_clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_reg <= `SBM_BUSY_RESET;
    end else if (h_cmd_wr || soft_clr) begin
      busy_reg <= 1'b1;
    end else if (cp_rd && cp_hit(cp_a, `SBM_CP_HCLR)) begin
      busy_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_lvl_reg <= 1'b0;
    end else if (cp_rd && cp_hit(cp_a, `SBM_CP_DRQ)) begin
      irq_lvl_reg <= 1'b1;
    end else if (h_cmd_wr || h_stat_rd || soft_clr) begin
      irq_lvl_reg <= 1'b0;
    end
  end

  // Disable bit only gates; the pending level is kept
  always_ff @(posedge sys_clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      host_irq <= 1'b0;
    end else begin
      host_irq <= irq_lvl_reg && !aux_reg[`SBM_AUX_IDS] && !busy_reg;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      drq_reg <= 1'b0;
    end else if (cp_wr && cp_hit(cp_a, `SBM_CP_DRQ)) begin
      drq_reg <= 1'b1;
    end else if (soft_clr || idle_cmd) begin
      drq_reg <= 1'b0;
    end else if (sec_end && !(multi_reg && sec_blk_reg > 8'h01)) begin
      drq_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sec_blk_reg <= 8'h00;
    end else if (cp_wr && cp_hit(cp_a, `SBM_CP_SECT)) begin
      sec_blk_reg <= cp_wdata;
    end else if (soft_clr) begin
      sec_blk_reg <= 8'h00;
    end else if (sec_end && sec_blk_reg != 8'h00) begin
      sec_blk_reg <= sec_blk_reg - 8'h01;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      read_mode_reg <= 1'b0;
      multi_reg <= 1'b0;
      ecc7_mode <= 1'b0;
      sleep_mode <= 1'b0;
    end else if (soft_clr) begin
      read_mode_reg <= 1'b0;
      multi_reg <= 1'b0;
      ecc7_mode <= 1'b0;
      sleep_mode <= 1'b0;
    end else begin
      if (cp_wr && cp_hit(cp_a, `SBM_CP_MODE)) begin
        read_mode_reg <= 1'b1;
      end else if (idle_cmd) begin
        read_mode_reg <= 1'b0;
      end
      if (cp_wr && cp_hit(cp_a, `SBM_CP_MULTI)) begin
        multi_reg <= 1'b1;
      end else if (cp_rd && cp_hit(cp_a, `SBM_CP_MULTI)) begin
        multi_reg <= 1'b0;
      end
      if (cp_rd && cp_hit(cp_a, `SBM_CP_DCLR)) begin
        ecc7_mode <= 1'b1;
      end
      if (cp_rd && cp_hit(cp_a, `SBM_CP_HCLR)) begin
        sleep_mode <= 1'b1;
      end else if (h_cmd_wr || idle_cmd) begin
        sleep_mode <= 1'b0;
      end
    end
  end

  // Wake-up stays low until the processor reads the command copy
  always_ff @(posedge sys_clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      processor_wakeup_n <= 1'b1;
    end else if (h_cmd_wr || soft_clr) begin
      processor_wakeup_n <= 1'b0;
    end else if (cp_rd && cp_a == {`SBM_CP_PAGE_OWN, 1'b0, `SBM_H_STAT}) begin
      processor_wakeup_n <= 1'b1;
    end
  end

  // Task file copies; processor write wins a same-cycle collision
  always_ff @(posedge sys_clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 1; i <= 6; i++) begin
        tf_reg[i] <= 8'h00;
      end
      cmd_reg <= 8'h00;
      stat_img_reg <= 8'h00;
    end else begin
      if (h_tf_wr) begin
        tf_reg[host_addr] <= host_wdata[7:0];
      end
      if (h_cmd_wr) begin
        cmd_reg <= host_wdata[7:0];
      end
      if (cp_wr && cp_a[5:3] == 3'h0) begin
        if (cp_a[2:0] == `SBM_H_STAT) begin
          stat_img_reg <= cp_wdata;
        end else if (cp_a[2:0] != `SBM_H_DATA) begin
          tf_reg[cp_a[2:0]] <= cp_wdata;
        end
      end
    end
  end

  // Host pipeline: two bytes moved per word, low byte first
  always_ff @(posedge sys_clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      host_lo_reg <= 8'h00;
      host_hi_reg <= 8'h00;
      host_pend_reg <= 2'h0;
      host_dir_wr_reg <= 1'b0;
    end else if (soft_clr) begin
      host_pend_reg <= 2'h0;
    end else if (h_data_wr) begin
      host_lo_reg <= host_wdata[7:0];
      host_hi_reg <= host_wdata[15:8];
      host_pend_reg <= 2'h2;
      host_dir_wr_reg <= 1'b1;
    end else if (h_data_rd || (cp_rd && cp_hit(cp_a, `SBM_CP_MODE))) begin
      host_pend_reg <= 2'h2;
      host_dir_wr_reg <= 1'b0;
    end else if (host_done) begin
      host_pend_reg <= host_pend_reg - 2'h1;
      if (!host_dir_wr_reg && hc_q[0]) begin
        host_hi_reg <= rd_byte;
      end else if (!host_dir_wr_reg) begin
        host_lo_reg <= rd_byte;
      end
    end
  end

  assign host_mr = '{addr: hc_q, we: host_dir_wr_reg, wdata: hc_q[0] ? host_hi_reg : host_lo_reg};
  assign dc_mr = '{addr: dcc_q, we: read_mode_reg, wdata: dc_pipe_reg};

  // Disk-side pipeline: one byte posted or prefetched at a time
  always_ff @(posedge sys_clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dc_pipe_reg <= 8'h00;
      dc_vld_reg <= 1'b0;
      dc_pend_reg <= 1'b0;
      dc_back <= 1'b0;
    end else if (soft_clr || (cp_wr && cp_hit(cp_a, `SBM_CP_DCLR))) begin
      dc_vld_reg <= 1'b0;
      dc_pend_reg <= 1'b0;
      dc_back <= 1'b0;
    end else begin
      dc_back <= 1'b0;
      if (dc_done) begin
        dc_pend_reg <= 1'b0;
        if (!read_mode_reg) begin
          dc_pipe_reg <= rd_byte;
          dc_vld_reg <= 1'b1;
        end
      end else if (!dc_pend_reg && !dc_back) begin
        if (read_mode_reg && dc_brq) begin
          dc_pipe_reg <= dc_din;
          dc_pend_reg <= 1'b1;
          dc_back <= 1'b1;
        end else if (!read_mode_reg && dc_vld_reg && dc_brq) begin
          dc_vld_reg <= 1'b0;
          dc_back <= 1'b1;
        end else if (!read_mode_reg && !dc_vld_reg) begin
          dc_pend_reg <= 1'b1;
        end
      end
    end
  end

  // Chip register access and byte hand-off share the chip data bus
  always_ff @(posedge sys_clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dc_bus <= '{addr: 3'h0, cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, dout: 8'h00};
      dc_rd_pend_reg <= 1'b0;
      dc_hold_reg <= 8'h00;
    end else begin
      dc_rd_pend_reg <= 1'b0;
      dc_bus.cs_n <= 1'b1;
      dc_bus.rd_n <= 1'b1;
      dc_bus.wr_n <= 1'b1;
      if ((cp_wr || cp_rd) && cp_a[5:4] == `SBM_CP_PAGE_DC && !cp_a[3]) begin
        dc_bus.addr <= cp_a[2:0];
        dc_bus.cs_n <= 1'b0;
        dc_bus.rd_n <= ~cp_rd;
        dc_bus.wr_n <= ~cp_wr;
        dc_rd_pend_reg <= cp_rd;
        if (cp_wr) begin
          dc_bus.dout <= cp_wdata;
        end
      end else if (!read_mode_reg && dc_vld_reg && dc_brq && !dc_pend_reg && !dc_back) begin
        dc_bus.dout <= dc_pipe_reg;
      end
      if (dc_rd_pend_reg) begin
        dc_hold_reg <= dc_din;
      end
    end
  end

  sbm_addr_ctr #(.W(`SBM_CTR_W), .BLK_LSB(`SBM_BLK_LSB)) u_host_ctr (
    .clk(sys_clk),
    .rst_n(rst_n_i),
    .clr(soft_clr || (cp_wr && cp_hit(cp_a, `SBM_CP_HCLR))),
    .ld(cp_wr && cp_hit(cp_a, `SBM_CP_HBLK)),
    .ld_blk(cp_wdata[4:0]),
    .inc(host_done),
    .q(hc_q)
  );

  sbm_addr_ctr #(.W(`SBM_CTR_W), .BLK_LSB(`SBM_BLK_LSB)) u_dc_ctr (
    .clk(sys_clk),
    .rst_n(rst_n_i),
    .clr(soft_clr || (cp_wr && cp_hit(cp_a, `SBM_CP_DCLR))),
    .ld(cp_wr && cp_hit(cp_a, `SBM_CP_DBLK)),
    .ld_blk(cp_wdata[4:0]),
    .inc(dc_done),
    .q(dcc_q)
  );

  sbm_seq u_seq (
    .clk(sys_clk),
    .rst_n(rst_n_i),
    .host_req(host_pend_reg != 2'h0),
    .host_mr(host_mr),
    .dc_req(dc_pend_reg),
    .dc_mr(dc_mr),
    .ram_din(ram_din),
    .ram(ram),
    .host_done(host_done),
    .dc_done(dc_done),
    .rd_byte(rd_byte)
  );

  // Processor read; chip registers return the previous chip read
  always_ff @(posedge sys_clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cp_rdata <= 8'h00;
    end else if (cp_rd) begin
      cp_rdata <= 8'h00;
      case (cp_a[5:4])
        `SBM_CP_PAGE_OWN: begin
          if (!cp_a[3] && cp_a[2:0] == `SBM_H_DATA) begin
            cp_rdata <= host_lo_reg;
          end else if (!cp_a[3] && cp_a[2:0] == `SBM_H_STAT) begin
            cp_rdata <= cmd_reg;
          end else if (!cp_a[3]) begin
            cp_rdata <= tf_reg[cp_a[2:0]];
          end
        end
        `SBM_CP_PAGE_DC: begin
          if (!cp_a[3]) begin
            cp_rdata <= dc_hold_reg;
          end
        end
        `SBM_CP_PAGE_SUP: begin
          if (cp_hit(cp_a, `SBM_CP_HBLK)) begin
            cp_rdata <= {3'h0, hc_q[13:9]};
          end else if (cp_hit(cp_a, `SBM_CP_DBLK)) begin
            cp_rdata <= {3'h0, dcc_q[13:9]};
          end
        end
        default: cp_rdata <= 8'h00;
      endcase
    end
  end

  // Host read; data word comes from the prefetched pair
  always_ff @(posedge sys_clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      host_rdata <= 16'h0000;
    end else if (host_rd) begin
      host_rdata <= 16'h0000;
      if (host_hit(host_cs_task, host_addr, `SBM_H_DATA)) begin
        host_rdata <= {host_hi_reg, host_lo_reg};
      end else if (host_hit(host_cs_task, host_addr, `SBM_H_STAT)) begin
        host_rdata <= {8'h00, status};
      end else if (host_cs_task) begin
        host_rdata <= {8'h00, tf_reg[host_addr]};
      end else if (host_hit(host_cs_aux, host_addr, `SBM_H_AUX)) begin
        host_rdata <= {8'h00, status};
      end
    end
  end

endmodule
